/* pwmoc_cfg.svh */
// Register offsets, field positions and reset values of the PWM timing block
`ifndef PWMOC_CFG_SVH
`define PWMOC_CFG_SVH

// Byte offsets of the three words on the bus
`define PWMOC_ON_OFS      8'h00
`define PWMOC_OFF_OFS     8'h04
`define PWMOC_SETUP_OFS   8'h08

// Field widths
`define PWMOC_CNT_W       16
`define PWMOC_SETUP_W     7
`define PWMOC_DIV_W       4

// Fields of the setup word
`define PWMOC_RUN_BIT     0
`define PWMOC_SEL_BIT     1
`define PWMOC_INV_BIT     2
`define PWMOC_DIV_LSB     3
`define PWMOC_DIV_MSB     6

// Reset values
`define PWMOC_ON_RST      16'h0000
`define PWMOC_OFF_RST     16'hffff
`define PWMOC_SETUP_RST   7'h00

`endif

/* pwmoc_pkg.sv */
// Types shared by the PWM timing block
package pwmoc_pkg;
  `include "pwmoc_cfg.svh"

  typedef enum logic [0:0] {
    ph_off = 1'b0,
    ph_on  = 1'b1
  } pwmoc_phase_e;

  // AHB-Lite request side, as driven by the master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } pwmoc_ahb_req_s;

  // Whole state of the block
  typedef struct packed {
    logic [`PWMOC_CNT_W-1:0]   on_vis;
    logic [`PWMOC_CNT_W-1:0]   off_vis;
    logic [`PWMOC_CNT_W-1:0]   on_hold;
    logic [`PWMOC_CNT_W-1:0]   off_hold;
    logic [3:0]                hold_full;
    logic [`PWMOC_SETUP_W-1:0] setup;
    logic [`PWMOC_DIV_W-1:0]   pre_cnt;
    logic [`PWMOC_CNT_W-1:0]   cnt;
    pwmoc_phase_e              phase;
    logic                      pwm;
    logic                      ap_valid;
    logic                      ap_write;
    logic [7:0]                ap_addr;
    logic [3:0]                ap_lanes;
    logic [31:0]               rdata;
  } pwmoc_state_s;
endpackage : pwmoc_pkg

/* pwmoc_core.sv */
// PWM generator: off-time, configuration, down counter and AHB-Lite slave
// Contract
// - Off-time field, reset all ones, makes off phase value plus one ticks
// - Off-time zero holds the output at its on level
// - Prescale field divides the selected source clock by value plus one
// - Prescale value zero lets counter run at the undivided source rate
// - Prescaled tick sets the decrement rate of the 16-bit down counter
// - Polarity bit set makes on level low, cleared makes it high
// - Clock-select bit picks slow source when set, fast source when clear
// - Run bit cleared resets counters and forces the off phase
// - Run bit cleared drives the inactive level given by polarity
// - Count registers keep contents and stay accessible while disabled
// - Run bit resets to zero and disabled block stops its counting
// - On-time value plus one ticks; zero with nonzero off holds full off
// - Count writes go to holding, applied after four bytes and off end; if full on or stopped, after four bytes alone
// - Sleep clears counters and puts phase and output to off
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/10ps
`include "pwmoc_cfg.svh"

module pwmoc_core (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire pwmoc_pkg::pwmoc_ahb_req_s ahb_req,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  input  wire logic                     fast_tick,
  input  wire logic                     slow_tick,
  input  wire logic                     sleep_req,
  output logic                          pwm_out
);
  import pwmoc_pkg::*;

  pwmoc_state_s st_reg;
  pwmoc_state_s st_next;

  logic                     run;
  logic                     invert;
  logic                     src_tick;
  logic [`PWMOC_DIV_W-1:0]  div;
  logic                     active;
  logic                     ptick;
  logic                     full_on;
  logic                     full_off;
  logic                     off_done;
  logic                     apply;
  logic                     wr;
  logic                     on_level;
  logic [3:0]               written;

  // Byte lanes touched by one transfer
  function automatic logic [3:0] pwmoc_lanes(input logic [2:0] size, input logic [1:0] a);
    case (size)
      3'h0:    return 4'h1 << a;
      3'h1:    return a[1] ? 4'hc : 4'h3;
      default: return 4'hf;
    endcase
  endfunction : pwmoc_lanes

  // Read view of a register, reserved bits as zero
  function automatic logic [31:0] pwmoc_read(input logic [7:0] a, input pwmoc_state_s s);
    case (a)
      `PWMOC_ON_OFS:    return {16'h0000, s.on_vis};
      `PWMOC_OFF_OFS:   return {16'h0000, s.off_vis};
      `PWMOC_SETUP_OFS: return {25'h0000000, s.setup};
      default:          return 32'h00000000;
    endcase
  endfunction : pwmoc_read

  assign run      = st_reg.setup[`PWMOC_RUN_BIT];
  assign invert   = st_reg.setup[`PWMOC_INV_BIT];
  assign div      = st_reg.setup[`PWMOC_DIV_MSB:`PWMOC_DIV_LSB];
  assign src_tick = st_reg.setup[`PWMOC_SEL_BIT] ? slow_tick : fast_tick;
  // Stopping the count stands in for gating the source clocks
  assign active   = run && !sleep_req;
  assign ptick    = active && src_tick && (st_reg.pre_cnt >= div);
  assign full_on  = (st_reg.off_vis == 16'h0000);
  assign full_off = (st_reg.on_vis == 16'h0000) && !full_on;
  assign off_done = ptick && (st_reg.phase == ph_off) && (st_reg.cnt == 16'h0000);
  assign apply    = (&st_reg.hold_full) && (off_done || full_on || !active);
  assign wr       = st_reg.ap_valid && st_reg.ap_write;
  assign on_level = active && (full_on || (!full_off && st_reg.phase == ph_on));

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_reg.rdata;
  assign pwm_out   = st_reg.pwm;

  always_comb
  begin
    st_next = st_reg;
    written = 4'h0;

    // Holding words and setup take the data phase of a write
    if (wr && st_reg.ap_addr == `PWMOC_ON_OFS)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (st_reg.ap_lanes[i])
        begin
          st_next.on_hold[i*8 +: 8] = ahb_req.hwdata[i*8 +: 8];
          written[i] = 1'b1;
        end
      end
    end
    if (wr && st_reg.ap_addr == `PWMOC_OFF_OFS)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (st_reg.ap_lanes[i])
        begin
          st_next.off_hold[i*8 +: 8] = ahb_req.hwdata[i*8 +: 8];
          written[i+2] = 1'b1;
        end
      end
    end
    if (wr && st_reg.ap_addr == `PWMOC_SETUP_OFS && st_reg.ap_lanes[0])
    begin
      st_next.setup = ahb_req.hwdata[`PWMOC_SETUP_W-1:0];
    end

    // A byte written in the cycle of the transfer stays marked
    if (apply)
    begin
      st_next.on_vis  = st_reg.on_hold;
      st_next.off_vis = st_reg.off_hold;
      st_next.hold_full = written;
    end
    else
    begin
      st_next.hold_full = st_reg.hold_full | written;
    end

    if (!active)
    begin
      st_next.pre_cnt = 4'h0;
      st_next.cnt     = 16'h0000;
      st_next.phase   = ph_off;
    end
    else
    begin
      if (src_tick)
      begin
        st_next.pre_cnt = ptick ? 4'h0 : st_reg.pre_cnt + 4'h1;
      end
      if (ptick)
      begin
        if (st_reg.cnt != 16'h0000)
        begin
          st_next.cnt = st_reg.cnt - 16'h0001;
        end
        else if (st_reg.phase == ph_off)
        begin
          st_next.phase = ph_on;
          st_next.cnt   = apply ? st_reg.on_hold : st_reg.on_vis;
        end
        else
        begin
          st_next.phase = ph_off;
          st_next.cnt   = st_reg.off_vis;
        end
      end
    end

    // Inactive level follows polarity while stopped
    st_next.pwm = on_level ^ invert;

    // Address phase; zero wait states so hreadyout is always high
    st_next.ap_valid = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    st_next.ap_write = ahb_req.hwrite;
    st_next.ap_addr  = ahb_req.haddr[7:0];
    st_next.ap_lanes = pwmoc_lanes(ahb_req.hsize, ahb_req.haddr[1:0]);
    // Read from next state so a write just before is seen
    st_next.rdata    = st_reg.rdata;
    if (st_next.ap_valid && !ahb_req.hwrite)
    begin
      st_next.rdata = pwmoc_read({ahb_req.haddr[7:2], 2'b00}, st_next);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg           <= '0;
      st_reg.on_vis    <= `PWMOC_ON_RST;
      st_reg.off_vis   <= `PWMOC_OFF_RST;
      st_reg.on_hold   <= `PWMOC_ON_RST;
      st_reg.off_hold  <= `PWMOC_OFF_RST;
      st_reg.setup     <= `PWMOC_SETUP_RST;
      st_reg.phase     <= ph_off;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence off_end_s;
    active && ptick && st_reg.phase == ph_off && st_reg.cnt == 16'h0000;
  endsequence

  sequence on_end_s;
    active && ptick && st_reg.phase == ph_on && st_reg.cnt == 16'h0000;
  endsequence

  sequence rd_addr_s(logic [7:0] ofs);
    ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready && !ahb_req.hwrite &&
      ahb_req.haddr[7:0] == ofs;
  endsequence

  // Steady stretches of a phase, outside the full on and full off overrides
  sequence on_run_s;
    active && !full_on && !full_off && st_reg.phase == ph_on;
  endsequence

  sequence off_run_s;
    active && !full_on && !full_off && st_reg.phase == ph_off;
  endsequence

  off_load_a: assert property (on_end_s |=> st_reg.phase == ph_off &&
                                st_reg.cnt == $past(st_reg.off_vis))
    else $error("off phase not loaded with off count");

  on_load_a: assert property (off_end_s ##0 !apply |=> st_reg.phase == ph_on &&
                               st_reg.cnt == $past(st_reg.on_vis))
    else $error("on phase not loaded with on count");

  full_on_a: assert property (active && full_on |=> pwm_out == !$past(invert))
    else $error("full on level not held");

  full_off_a: assert property (active && full_off |=> pwm_out == $past(invert))
    else $error("full off level not held");

  idle_level_a: assert property (!run |=> pwm_out == $past(invert))
    else $error("disabled output not at inactive level");

  stop_clear_a: assert property (!run |=> st_reg.cnt == 16'h0000 &&
                                  st_reg.pre_cnt == 4'h0 && st_reg.phase == ph_off)
    else $error("disable did not clear counters");

  sleep_clear_a: assert property (sleep_req |=> st_reg.cnt == 16'h0000 &&
                                   st_reg.phase == ph_off && pwm_out == $past(invert))
    else $error("sleep did not force off state");

  pre_step_a: assert property (active && src_tick && st_reg.pre_cnt < div |=>
                                st_reg.pre_cnt == $past(st_reg.pre_cnt) + 4'h1 &&
                                st_reg.cnt == $past(st_reg.cnt))
    else $error("prescaler step wrong");

  bypass_dec_a: assert property (active && src_tick && div == 4'h0 &&
                                  st_reg.cnt != 16'h0000 |=>
                                  st_reg.cnt == $past(st_reg.cnt) - 16'h0001)
    else $error("undivided count did not decrement");

  hold_apply_a: assert property (apply |=> st_reg.on_vis == $past(st_reg.on_hold) &&
                                  st_reg.off_vis == $past(st_reg.off_hold))
    else $error("holding words not applied");

  no_apply_a: assert property (!(&st_reg.hold_full) |=>
                                $stable(st_reg.on_vis) && $stable(st_reg.off_vis))
    else $error("visible count changed without full holding set");

  read_vis_a: assert property (rd_addr_s(`PWMOC_OFF_OFS) ##0 !apply |=>
                                hrdata == {16'h0000, $past(st_reg.off_vis)})
    else $error("off count read did not return visible value");

  sel_src_a: assert property (active && !st_reg.setup[`PWMOC_SEL_BIT] &&
                               !fast_tick |=> $stable(st_reg.pre_cnt) && $stable(st_reg.cnt))
    else $error("counter moved without fast source tick");

  // Pin level and count stepping within each phase
  on_level_a: assert property (on_run_s |=> pwm_out == !$past(invert))
    else $error("on phase level wrong");

  off_level_a: assert property (off_run_s |=> pwm_out == $past(invert))
    else $error("off phase level wrong");

  off_step_a: assert property (active && ptick && st_reg.phase == ph_off &&
                                st_reg.cnt != 16'h0000 |=> st_reg.phase == ph_off &&
                                st_reg.cnt == $past(st_reg.cnt) - 16'h0001)
    else $error("off count did not step down");

  on_step_a: assert property (active && ptick && st_reg.phase == ph_on &&
                               st_reg.cnt != 16'h0000 |=> st_reg.phase == ph_on &&
                               st_reg.cnt == $past(st_reg.cnt) - 16'h0001)
    else $error("on count did not step down");

  count_hold_a: assert property (active && !ptick |=> $stable(st_reg.cnt) &&
                                  $stable(st_reg.phase))
    else $error("counter moved without prescaled tick");

  pre_wrap_a: assert property (ptick |=> st_reg.pre_cnt == 4'h0)
    else $error("prescaler not restarted after tick");

  slow_src_a: assert property (active && st_reg.setup[`PWMOC_SEL_BIT] &&
                                !slow_tick |=> $stable(st_reg.pre_cnt) && $stable(st_reg.cnt))
    else $error("counter moved without slow source tick");

  // Register writes, holding words and their transfer
  setup_wr_a: assert property (wr && st_reg.ap_addr == `PWMOC_SETUP_OFS &&
                                st_reg.ap_lanes[0] |=>
                                st_reg.setup == $past(ahb_req.hwdata[`PWMOC_SETUP_W-1:0]))
    else $error("setup write not taken");

  hold_wr_a: assert property (wr && st_reg.ap_addr == `PWMOC_OFF_OFS &&
                               st_reg.ap_lanes == 4'hf |=>
                               st_reg.off_hold == $past(ahb_req.hwdata[15:0]))
    else $error("off holding word not written");

  hold_on_wr_a: assert property (wr && st_reg.ap_addr == `PWMOC_ON_OFS &&
                                  st_reg.ap_lanes == 4'hf |=>
                                  st_reg.on_hold == $past(ahb_req.hwdata[15:0]))
    else $error("on holding word not written");

  flags_clear_a: assert property (apply && !wr |=> st_reg.hold_full == 4'h0)
    else $error("holding flags not cleared after apply");

  full_on_apply_a: assert property ((&st_reg.hold_full) && full_on |=>
                                     st_reg.on_vis == $past(st_reg.on_hold))
    else $error("full on state did not take holding words");

  idle_apply_a: assert property (!run && (&st_reg.hold_full) |=>
                                  st_reg.off_vis == $past(st_reg.off_hold))
    else $error("disabled block did not take holding words");

  // Read data stands in the data phase
  read_on_a: assert property (rd_addr_s(`PWMOC_ON_OFS) ##0 !apply |=>
                               hrdata == {16'h0000, $past(st_reg.on_vis)})
    else $error("on count read did not return visible value");

  read_setup_a: assert property (rd_addr_s(`PWMOC_SETUP_OFS) ##0 !wr |=>
                                  hrdata == {25'h0000000, $past(st_reg.setup)})
    else $error("setup read wrong");

  read_gap_a: assert property (rd_addr_s(8'h0c) |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule : pwmoc_core

/* pwmoc_dummy_never.sv */
// Spare source slot of the PWM timing block; holds no logic
`timescale 1ns/10ps

/* pwmoc_load.sv */
// Pin load model that measures how long the output stays at each level
`timescale 1ns/10ps

module pwmoc_load (
  input  wire logic clock,
  input  wire logic pwm_in,
  output int        hi_len,
  output int        lo_len
);
  int   run;
  logic prev;

  initial
  begin
    run = 0;
    prev = 1'b0;
    hi_len = 0;
    lo_len = 0;
  end

  // Every run is reported at the next level change, so a run cut by a change of setup shows too
  always @(posedge clock)
  begin
    if (pwm_in !== prev)
    begin
      if (prev === 1'b1)
        hi_len <= run;
      else
        lo_len <= run;
      run <= 1;
    end
    else
      run <= run + 1;
    prev <= pwm_in;
  end
endmodule : pwmoc_load

/* tb.sv */
// Self-checking bench for the PWM timing block
`timescale 1ns/10ps

module tb;
  import pwmoc_pkg::*;
  logic           clock;
  logic           rst_n;
  logic           hsel;
  logic [31:0]    haddr;
  logic [1:0]     htrans;
  logic           hwrite;
  logic [31:0]    hwdata;
  logic           fast_tick;
  logic           slow_tick;
  logic           sleep_req;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           hresp;
  logic           pwm_out;
  logic [31:0]    rd;
  logic [7:0]     tick_cnt;
  int             hi_len;
  int             lo_len;
  int             n_errors;
  int             num_checks;
  int             cyc;
  pwmoc_ahb_req_s ahb_req;

  assign ahb_req = {hsel, haddr, htrans, hwrite, 3'b010, hwdata, hreadyout};

  pwmoc_core i_dut (.clock(clock), .rst_n(rst_n), .ahb_req(ahb_req), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fast_tick(fast_tick), .slow_tick(slow_tick),
    .sleep_req(sleep_req), .pwm_out(pwm_out));

  pwmoc_load i_load (.clock(clock), .pwm_in(pwm_out), .hi_len(hi_len), .lo_len(lo_len));

  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Fast source every 2 cycles, slow every 8, so the two rates differ
  always @(posedge clock)
  begin
    tick_cnt <= tick_cnt + 8'h01;
    fast_tick <= tick_cnt[0];
    slow_tick <= (tick_cnt[2:0] == 3'h7);
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
    chk("ready", 32'h1, {31'h0, hreadyout});
    chk("resp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic pin_hold(input logic lvl);
    for (int i = 0; i < 5; i++)
    begin
      repeat (7) @(posedge clock);
      chk("held pin", {31'h0, lvl}, {31'h0, pwm_out});
    end
  endtask : pin_hold

  // On count 1 and off count 2 give runs of 2 and 3 prescaled ticks
  task automatic run_cfg(input logic sel, input logic inv, input logic [3:0] dv);
    int per;
    per = (sel ? 8 : 2) * (int'(dv) + 1);
    bus(1'b1, 8'h08, {25'h0, dv, inv, sel, 1'b1});
    repeat (700) @(posedge clock);
    chk("high run", 32'(inv ? 3 * per : 2 * per), 32'(hi_len));
    chk("low run", 32'(inv ? 2 * per : 3 * per), 32'(lo_len));
    bus(1'b1, 8'h08, {25'h0, dv, inv, sel, 1'b0});
    repeat (3) @(posedge clock);
    chk("idle pin", {31'h0, inv}, {31'h0, pwm_out});
    $display("test setup sel %0d inv %0d div %0d done", sel, inv, dv);
  endtask : run_cfg

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sleep_req = 1'b0;
    fast_tick = 1'b0;
    slow_tick = 1'b0;
    tick_cnt = 8'h00;
    cyc = 0;
    n_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("reset pin", 32'h0, {31'h0, pwm_out});
    rchk(8'h00, 32'h0000_0000, "on reset");
    rchk(8'h04, 32'h0000_ffff, "off reset");
    rchk(8'h08, 32'h0000_0000, "setup reset");
    rchk(8'h0c, 32'h0000_0000, "unmapped");
    bus(1'b1, 8'h00, 32'habcd_0001);
    bus(1'b1, 8'h04, 32'h0000_0002);
    rchk(8'h00, 32'h0000_0001, "on idle write");
    rchk(8'h04, 32'h0000_0002, "off idle write");
    $display("test registers done");
    run_cfg(1'b0, 1'b0, 4'h0);
    run_cfg(1'b0, 1'b1, 4'h1);
    run_cfg(1'b1, 1'b0, 4'h2);
    run_cfg(1'b1, 1'b1, 4'h0);
    // Half of the holding words must not reach the counter
    bus(1'b1, 8'h08, 32'h0000_0001);
    bus(1'b1, 8'h00, 32'h0000_0004);
    repeat (50) @(posedge clock);
    rchk(8'h00, 32'h0000_0001, "on partial");
    bus(1'b1, 8'h04, 32'h0000_0003);
    repeat (200) @(posedge clock);
    rchk(8'h00, 32'h0000_0004, "on applied");
    chk("high run", 32'd10, 32'(hi_len));
    chk("low run", 32'd8, 32'(lo_len));
    $display("test holding done");
    sleep_req <= 1'b1;
    repeat (3) @(posedge clock);
    chk("sleep pin", 32'h0, {31'h0, pwm_out});
    sleep_req <= 1'b0;
    $display("test sleep done");
    bus(1'b1, 8'h00, 32'h0000_0004);
    bus(1'b1, 8'h04, 32'h0000_0000);
    repeat (200) @(posedge clock);
    pin_hold(1'b1);
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h04, 32'h0000_0002);
    repeat (200) @(posedge clock);
    pin_hold(1'b0);
    $display("test full levels done");
    conclude();
  end
endmodule : tb
